//--- logic/rpsl_pin_select.sv
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns
// Operation
// - at most 44 remappable pins exist, the last 12 of them input-only.
// - every select field is six bits, naming up to 64 pins (input) or output codes.
// - input select naming an absent pin, above 43 included, connects nothing.
// - output select fields of absent pins ignore writes and read zero.
// - while locked, select writes complete normally but change nothing.
// - lock sits at bit 6 of oscillator control; one blocks writes.
// - lock changes only in the write right after keys 46h then 57h.
// - lock holds its value until changed again through the key.
// - shadow copies watched; any mismatch raises configuration mismatch reset.
// - with one-way set, a set lock can never be cleared until reset.
// - one-way bit defaults to one; zero allows unlimited unlock sessions.
// - inputs reset to pin 63 (tied low); outputs reset to code zero.
// - lock comes out of reset cleared.
// - mapping never changes pin direction nor enables the peripheral.
// - mapping does not override analog pins; digital set elsewhere.
// - input field picks the pin whose number drives the peripheral input.
// - output field per pin holds a code; zero leaves output disabled.
// - one pin may feed many inputs; one output may drive many pins.
module rpsl_pin_select #(
    parameter int N_IN     = 35,
    parameter int N_PINS   = 44,
    parameter int N_IO     = 32,
    parameter int N_OUTFN  = 64
) (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    // pins and peripherals
    input  wire logic [N_PINS-1:0]        pin_in,
    input  wire logic [N_OUTFN-1:0]       periph_out,
    output logic [N_IN-1:0]               periph_in,
    output logic [N_IO-1:0]               pin_out,
    output logic [N_IO-1:0]               pin_out_active,
    // status
    output logic                          cfg_mismatch_rst
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [5:0]            in_sel_q  [N_IN];
    logic [5:0]            in_sel_d  [N_IN];
    logic [5:0]            in_shd_q  [N_IN];
    logic [5:0]            out_sel_q [N_IO];
    logic [5:0]            out_sel_d [N_IO];
    logic [5:0]            out_shd_q [N_IO];
    logic                  lock_q;
    logic                  lock_d;
    logic                  one_way_q;
    logic                  one_way_d;
    logic                  mism_q;
    logic                  mism_d;
    rpsl_pkg::rpsl_key_t   key_q;
    rpsl_pkg::rpsl_key_t   key_d;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic [N_IN-1:0]       pin_in_mux_d;
    logic [N_IN-1:0]       periph_in_q;
    logic [N_IO-1:0]       pin_out_d;
    logic [N_IO-1:0]       pin_out_q;
    logic [N_IO-1:0]       pin_act_d;
    logic [N_IO-1:0]       pin_act_q;
    logic                  pready_q;
    logic                  pslverr_q;
    // one-hot address match per select entry
    logic [N_IN-1:0]       in_hit;
    logic [N_IO-1:0]       out_hit;

    logic                  wr_en;
    logic                  rd_setup;
    logic                  osc_hit;
    logic                  cfg_hit;
    logic                  stat_hit;
    logic                  sel_wr_ok;
    logic [7:0]            wbyte;
    logic                  lock_req;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign wr_en     = psel && penable && pwrite;
    // read data is latched in setup so it stands through the access cycle
    assign rd_setup  = psel && !penable && !pwrite;
    assign osc_hit   = (paddr == rpsl_pkg::OSC_CTRL_OFS);
    assign cfg_hit   = (paddr == rpsl_pkg::CFG_OFS);
    assign stat_hit  = (paddr == rpsl_pkg::STATUS_OFS);
    // only the low byte carries the key and the lock request
    assign wbyte     = pwdata[7:0];
    assign lock_req  = wbyte[rpsl_pkg::LOCK_BIT];
    assign sel_wr_ok = wr_en && !lock_q;

    // ------------------------------------------------------------
    // key detector, lock and config bit
    // ------------------------------------------------------------
    // any stray write voids a half-entered key
    always_comb begin
        key_d     = key_q;
        lock_d    = lock_q;
        one_way_d = one_way_q;
        if (wr_en) begin
            key_d = rpsl_pkg::RPSL_KEY_IDLE;
            if (osc_hit) begin
                unique case (key_q)
                    rpsl_pkg::RPSL_KEY_IDLE: begin
                        if (wbyte == rpsl_pkg::KEY_FIRST) begin
                            key_d = rpsl_pkg::RPSL_KEY_GOT1;
                        end
                    end
                    rpsl_pkg::RPSL_KEY_GOT1: begin
                        if (wbyte == rpsl_pkg::KEY_SECOND) begin
                            key_d = rpsl_pkg::RPSL_KEY_GOT2;
                        end else if (wbyte == rpsl_pkg::KEY_FIRST) begin
                            // a repeated first key keeps the sequence armed
                            key_d = rpsl_pkg::RPSL_KEY_GOT1;
                        end
                    end
                    rpsl_pkg::RPSL_KEY_GOT2: begin
                        // under one-way a set lock cannot be cleared
                        if (!(one_way_q && lock_q && !lock_req)) begin
                            lock_d = lock_req;
                        end
                    end
                endcase
            end else if (cfg_hit && !lock_q) begin
                // fuse stand-in frozen while locked, else one-way could be undone
                one_way_d = pwdata[rpsl_pkg::ONE_WAY_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_q     <= rpsl_pkg::RPSL_KEY_IDLE;
            lock_q    <= rpsl_pkg::LOCK_RST;
            one_way_q <= rpsl_pkg::ONE_WAY_RST;
        end else begin
            key_q     <= key_d;
            lock_q    <= lock_d;
            one_way_q <= one_way_d;
        end
    end

    // ------------------------------------------------------------
    // select registers, shadows and routing
    // ------------------------------------------------------------
    // mux per entry; no pin direction or peripheral enable touched here
    for (genvar i = 0; i < N_IN; i++) begin : g_in
        assign in_hit[i] = (paddr == rpsl_pkg::IN_SEL_BASE + 12'(4 * i));
        always_comb begin
            in_sel_d[i] = in_sel_q[i];
            if (sel_wr_ok && in_hit[i]) begin
                in_sel_d[i] = pwdata[5:0];
            end
            // absent pins (63 included) read as ground
            pin_in_mux_d[i] = (in_sel_q[i] < 6'(N_PINS)) ? pin_in[in_sel_q[i]] : 1'b0;
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                in_sel_q[i] <= rpsl_pkg::IN_SEL_RST;
                in_shd_q[i] <= rpsl_pkg::IN_SEL_RST;
            end else begin
                in_sel_q[i] <= in_sel_d[i];
                // shadow takes the same next value; only a disturbed cell differs
                in_shd_q[i] <= in_sel_d[i];
            end
        end
    end

    for (genvar j = 0; j < N_IO; j++) begin : g_out
        assign out_hit[j] = (paddr == rpsl_pkg::OUT_SEL_BASE + 12'(4 * j));
        always_comb begin
            out_sel_d[j] = out_sel_q[j];
            if (sel_wr_ok && out_hit[j]) begin
                out_sel_d[j] = pwdata[5:0];
            end
            pin_act_d[j] = (out_sel_q[j] != rpsl_pkg::OUT_CODE_NULL);
            // gated so a null pin shows low rather than the output of function zero
            pin_out_d[j] = pin_act_d[j] ? periph_out[out_sel_q[j]] : 1'b0;
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_sel_q[j] <= rpsl_pkg::OUT_SEL_RST;
                out_shd_q[j] <= rpsl_pkg::OUT_SEL_RST;
            end else begin
                out_sel_q[j] <= out_sel_d[j];
                out_shd_q[j] <= out_sel_d[j];
            end
        end
    end

    // sticky until device reset; a flipped cell cannot clear itself
    always_comb begin
        mism_d = mism_q;
        for (int k = 0; k < N_IN; k++) begin
            if (in_sel_q[k] != in_shd_q[k]) begin
                mism_d = 1'b1;
            end
        end
        for (int k = 0; k < N_IO; k++) begin
            if (out_sel_q[k] != out_shd_q[k]) begin
                mism_d = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // apb read data
    // ------------------------------------------------------------
    // writes to absent output fields decode to nothing and read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_setup) begin
            if (osc_hit) begin
                rdata_d[rpsl_pkg::LOCK_BIT] = lock_q;
            end else if (cfg_hit) begin
                rdata_d[rpsl_pkg::ONE_WAY_BIT] = one_way_q;
            end else if (stat_hit) begin
                // sticky mismatch flag and the detector state
                rdata_d[rpsl_pkg::STAT_MISM_BIT] = mism_q;
                rdata_d[rpsl_pkg::STAT_KEY_LSB +: 2] = key_q;
            end
            for (int k = 0; k < N_IN; k++) begin
                if (in_hit[k]) begin
                    rdata_d[5:0] = in_sel_q[k];
                end
            end
            for (int k = 0; k < N_IO; k++) begin
                if (out_hit[k]) begin
                    rdata_d[5:0] = out_sel_q[k];
                end
            end
        end else if (psel && penable) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_in_q <= '0;
            pin_out_q   <= '0;
            pin_act_q   <= '0;
        end else begin
            periph_in_q <= pin_in_mux_d;
            pin_out_q   <= pin_out_d;
            pin_act_q   <= pin_act_d;
        end
    end

    // cleared only by device reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mism_q <= rpsl_pkg::MISM_RST;
        end else begin
            mism_q <= mism_d;
        end
    end

    // holds through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // apb response
    // ------------------------------------------------------------
    // zero wait states; ready drops only while in reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= 1'b1;
            pslverr_q <= 1'b0;
        end
    end

    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign prdata           = rdata_q;
    assign periph_in        = periph_in_q;
    assign pin_out          = pin_out_q;
    assign pin_out_active   = pin_act_q;
    assign cfg_mismatch_rst = mism_q;

endmodule : rpsl_pin_select

//--- logic/rpsl_pkg.sv
package rpsl_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OSC_CTRL_OFS   = 12'h000;
    localparam logic [11:0] CFG_OFS        = 12'h004;
    localparam logic [11:0] STATUS_OFS     = 12'h008;
    localparam logic [11:0] IN_SEL_BASE    = 12'h100;
    localparam logic [11:0] OUT_SEL_BASE   = 12'h200;

    // ------------------------------------------------------------
    // fields and values
    // ------------------------------------------------------------
    localparam int          LOCK_BIT       = 6;
    localparam int          ONE_WAY_BIT    = 4;
    localparam int          SEL_W          = 6;
    localparam logic [7:0]  KEY_FIRST      = 8'h46;
    localparam logic [7:0]  KEY_SECOND     = 8'h57;
    localparam logic [5:0]  IN_SEL_RST     = 6'h3f;
    localparam logic [5:0]  OUT_SEL_RST    = 6'h00;
    localparam logic [5:0]  OUT_CODE_NULL  = 6'h00;
    localparam logic        ONE_WAY_RST    = 1'b1;
    localparam logic        LOCK_RST       = 1'b0;
    localparam logic        MISM_RST       = 1'b0;
    localparam int          STAT_MISM_BIT  = 0;
    localparam int          STAT_KEY_LSB   = 1;

    typedef enum logic [1:0] {
        RPSL_KEY_IDLE,
        RPSL_KEY_GOT1,
        RPSL_KEY_GOT2
    } rpsl_key_t;

endpackage : rpsl_pkg

//--- verif/rpsl_far_model.sv
`timescale 1ns/1ns
module rpsl_far_model (
    // clock and picks
    input wire logic [5:0] pin_pick,
    input wire logic [5:0] fn_pick,
    input wire logic       pclk,
    // pins and peripherals
    output logic [43:0]    pin_in,
    output logic [63:0]    periph_out
);
    // pick 63 drives every pin high so dead routes show up
    always_ff @(posedge pclk) begin
        pin_in     <= (pin_pick == 6'h3f) ? '1 : 44'h1 << pin_pick;
        periph_out <= 64'h1 << fn_pick;
    end
endmodule : rpsl_far_model

//--- verif/rpsl_props.sv
`timescale 1ns/1ns
module rpsl_props #(
    parameter int N_IN   = 35,
    parameter int N_PINS = 44,
    parameter int N_IO   = 32
) (
    // apb
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    // routing
    input wire logic [N_PINS-1:0] pin_in,
    input wire logic [N_IN-1:0]   periph_in,
    input wire logic [N_IO-1:0]   pin_out_active,
    input wire logic              cfg_mismatch_rst
);
    logic       wr, rd, lk_q, ow_q;
    logic [1:0] ks_q;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & !pwrite;
    // ------------------------------------------------------------
    // key tracker, mirrors the lock for read-back
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ks_q <= 2'h0;
            lk_q <= 1'b0;
            ow_q <= 1'b1;
        end else if (wr) begin
            ks_q <= (paddr != 12'h000 || ks_q == 2'h2) ? 2'h0 : (pwdata[7:0] == 8'h46) ? 2'h1 :
                    (ks_q == 2'h1 && pwdata[7:0] == 8'h57) ? 2'h2 : 2'h0;
            if (ks_q == 2'h2 && paddr == 12'h000 && !(ow_q && lk_q && !pwdata[6]))
                lk_q <= pwdata[6];
            if (paddr == 12'h004 && !lk_q)
                ow_q <= pwdata[4];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel |-> pready && !pslverr; endproperty
    a_ready: assert property (p_ready) else $error("select access stalled or errored");
    property p_rst; $rose(presetn) |-> pin_out_active == '0 && periph_in == '0; endproperty
    a_rst: assert property (p_rst) else $error("routing live after reset");
    property p_mm; !cfg_mismatch_rst; endproperty
    a_mm: assert property (p_mm) else $error("mismatch reset without disturbance");
    property p_lock; rd && paddr == 12'h000 |-> prdata[6] == lk_q; endproperty
    a_lock: assert property (p_lock) else $error("lock bit wrong");
    property p_unmap; rd && paddr >= 12'h280 |-> prdata == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("absent register not zero");
    property p_quiet; !$past(wr) && !$past(wr, 2) |-> $stable(pin_out_active); endproperty
    a_quiet: assert property (p_quiet) else $error("output enable moved alone");
    property p_held; wr && paddr[11:8] == 4'h2 && lk_q |=> $stable(pin_out_active)[*2]; endproperty
    a_held: assert property (p_held) else $error("locked write took effect");
    property p_in; $past(pin_in) == $past(pin_in, 2) && !$past(wr, 2) && !$past(wr, 3) |-> $stable(periph_in);
    endproperty
    a_in: assert property (p_in) else $error("input route moved alone");
endmodule : rpsl_props
bind rpsl_pin_select rpsl_props #(.N_IN(N_IN), .N_PINS(N_PINS), .N_IO(N_IO)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .periph_in(periph_in),
    .pin_out_active(pin_out_active), .cfg_mismatch_rst(cfg_mismatch_rst));

//--- verif/test_remappable_pin_select_lock.sv
`timescale 1ns/1ns
module test_remappable_pin_select_lock;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata, pin_out, pin_out_active;
    logic [5:0]  pin_pick = 6'h00, fn_pick = 6'h00;
    logic        pready, pslverr, cfg_mismatch_rst;
    logic [43:0] pin_in;
    logic [63:0] periph_out;
    logic [34:0] periph_in;
    int          num_errors = 0, num_checks = 0;
    initial forever #25 pclk = ~pclk;
    rpsl_pin_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in),
        .periph_out(periph_out), .periph_in(periph_in), .pin_out(pin_out), .pin_out_active(pin_out_active),
        .cfg_mismatch_rst(cfg_mismatch_rst));
    rpsl_far_model u_far (.pclk(pclk), .pin_pick(pin_pick), .fn_pick(fn_pick), .pin_in(pin_in),
        .periph_out(periph_out));
    // psel stays up between transfers; rel drops it
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        penable <= 1'b0;
    endtask : xfer
    task automatic rel;
        psel <= 1'b0;
        @(posedge pclk);
    endtask : rel
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask : rchk
    task automatic lk(input logic e);
        xfer(1'b0, 12'h000, 32'h0);
        chk("lock", {31'h0, e}, {31'h0, rd[6]});
    endtask : lk
    task automatic key(input logic [31:0] v);
        xfer(1'b1, 12'h000, 32'h46);
        xfer(1'b1, 12'h000, 32'h57);
        xfer(1'b1, 12'h000, v);
    endtask : key
    task automatic do_reset;
        psel <= 1'b0;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset
    task automatic route(input logic [5:0] p, input logic [31:0] e);
        rel();
        pin_pick <= p;
        repeat (3) @(posedge pclk);
        chk("periph_in", e, periph_in[31:0]);
    endtask : route
    task automatic t_route;
        rchk(12'h188, 32'h3f);
        rchk(12'h27c, 32'h0);
        lk(1'b0);
        xfer(1'b1, 12'h100, 32'h5);
        xfer(1'b1, 12'h104, 32'h5);
        xfer(1'b1, 12'h108, 32'h2b);
        xfer(1'b1, 12'h10c, 32'h2c);
        xfer(1'b1, 12'h208, 32'h3);
        xfer(1'b1, 12'h20c, 32'h3);
        xfer(1'b1, 12'h280, 32'h3);
        rchk(12'h280, 32'h0);
        rchk(12'h10c, 32'h2c);
        fn_pick <= 6'h03;
        route(6'h05, 32'h3);
        chk("pin_out", 32'hc, pin_out);
        chk("active", 32'hc, pin_out_active);
        route(6'h2b, 32'h4);
        route(6'h3f, 32'h7);
    endtask : t_route
    task automatic t_lock;
        rchk(12'h004, 32'h10);
        key(32'h40);
        lk(1'b1);
        xfer(1'b1, 12'h100, 32'h9);
        xfer(1'b1, 12'h208, 32'h0);
        rchk(12'h100, 32'h5);
        key(32'h0);
        lk(1'b1);
        xfer(1'b1, 12'h004, 32'h0);
        key(32'h0);
        lk(1'b1);
        do_reset();
        lk(1'b0);
    endtask : t_lock
    task automatic t_unlimited;
        xfer(1'b1, 12'h004, 32'h0);
        key(32'h40);
        key(32'h0);
        lk(1'b0);
        xfer(1'b1, 12'h100, 32'h9);
        rchk(12'h100, 32'h9);
        xfer(1'b1, 12'h000, 32'h46);
        rchk(12'h008, 32'h2);
        xfer(1'b1, 12'h104, 32'h1);
        xfer(1'b1, 12'h000, 32'h57);
        xfer(1'b1, 12'h000, 32'h40);
        lk(1'b0);
        rchk(12'h300, 32'h0);
        chk("mismatch", 32'h0, {31'h0, cfg_mismatch_rst});
    endtask : t_unlimited
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    initial begin
        do_reset();
        t_route();
        t_lock();
        t_unlimited();
        rel();
        give_verdict();
    end
    initial begin
        repeat (3000) @(posedge pclk);
        num_errors++;
        give_verdict();
    end
endmodule : test_remappable_pin_select_lock
